// ---- pkg/mem_decode_defs.svh ----
// Constants for the module memory decoder and link configuration
`ifndef MEM_DECODE_DEFS_SVH
`define MEM_DECODE_DEFS_SVH

// Address map in the processor's signed byte address space
`define ONCHIP_TAG        20'h80000
`define ONCHIP_TAG_LSB    12
`define EXT_BASE          32'h8000_1000
`define DRAM_SPAN_BITS    22
`define WORD_LSB          2

// Clock and external memory timing
`define CLOCK_NS          25
`define DRAM_WAIT_STATES  1
`define DRAM_CYCLE_NS     160
`define DRAM_CYCLES       ((`DRAM_CYCLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)

// Serial link bit periods: 10 Mbit/s and 20 Mbit/s
`define LINK_COUNT        4
`define LINK_SLOW_NS      100
`define LINK_FAST_NS      50
`define LINK_SLOW_CYCLES  (`LINK_SLOW_NS / `CLOCK_NS)
`define LINK_FAST_CYCLES  (`LINK_FAST_NS / `CLOCK_NS)

// Reset values
`define RSP_DATA_RST      32'h0000_0000
`define BIT_CNT_RST       3'h0

`endif

// ---- pkg/mem_decode_pkg.sv ----
// Types shared by the memory decoder and its external memory store
package mem_decode_pkg;

   typedef logic [31:0] addr_t;
   typedef logic [31:0] data_t;
   typedef logic [3:0]  byteEn_t;
   typedef logic [3:0]  linkVec_t;

   // One-hot access sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_ACK  = 3'b100
   } accState_t;

endpackage

// ---- pkg/dram_if.sv ----
// Connection between the access sequencer and the external memory store
`timescale 1ns/1ps
interface dram_if #(
   parameter int AW = 20
);
   logic                 en;
   logic                 we;
   logic [AW-1:0]        addr;
   mem_decode_pkg::data_t wdata;
   mem_decode_pkg::byteEn_t be;
   mem_decode_pkg::data_t rdata;

   modport ctrl (output en, output we, output addr, output wdata, output be, input rdata);
   modport mem  (input en, input we, input addr, input wdata, input be, output rdata);
endinterface

// ---- core/dram_store.sv ----
// External dynamic memory array with per-byte writes and registered read data
`timescale 1ns/1ps
module dram_store #(
   parameter int AW = 20
) (
   input wire logic clock,
   dram_if.mem      bus
);
   import mem_decode_pkg::*;

   logic [7:0] rdLane_q [4];

   // One byte lane per generate pass so byte enables never need a read-modify-write
   for (genvar g = 0; g < 4; g++) begin : gLane
      logic [7:0] lane [2**AW];

      always_ff @(posedge clock) begin
         if (bus.en && bus.we && bus.be[g]) begin
            lane[bus.addr] <= bus.wdata[8*g +: 8];
         end
      end

      // Read data held until the next read
      always_ff @(posedge clock) begin
         if (bus.en && !bus.we) begin
            rdLane_q[g] <= lane[bus.addr];
         end
      end
   end

   assign bus.rdata = {rdLane_q[3], rdLane_q[2], rdLane_q[1], rdLane_q[0]};

endmodule

// ---- core/mem_decode_link_cfg.sv ----
// Module memory decoder, link rate straps and fault line logic
`include "mem_decode_defs.svh"
`timescale 1ns/1ps
module mem_decode_link_cfg #(
   parameter int AW = 20
) (
   input  wire logic                     clock,
   input  wire logic                     srst,
   // Processor memory access port
   input  wire logic                     reqValid,
   output logic                          reqReady,
   input  mem_decode_pkg::addr_t         reqAddr,
   input  wire logic                     reqWrite,
   input  mem_decode_pkg::data_t         reqWdata,
   input  mem_decode_pkg::byteEn_t       reqBe,
   output logic                          onChipSel,
   output logic                          rspValid,
   output mem_decode_pkg::data_t         rspData,
   output logic                          rspOnChip,
   // Link rate straps and derived rates
   input  wire logic                     link0RateStrap,
   input  wire logic                     links123RateStrap,
   output mem_decode_pkg::linkVec_t      linkRateHigh,
   output mem_decode_pkg::linkVec_t      linkBitTick,
   // Serial links
   input  mem_decode_pkg::linkVec_t      serialLinkRx,
   input  mem_decode_pkg::linkVec_t      serialLinkRxConn,
   output mem_decode_pkg::linkVec_t      linkRxToCore,
   input  mem_decode_pkg::linkVec_t      coreLinkTx,
   output mem_decode_pkg::linkVec_t      serialLinkTx,
   // Shared open-drain fault line
   input  wire logic                     coreError,
   input  wire logic                     moduleFaultLowIn,
   output logic                          moduleFaultLowOut,
   output logic                          moduleFaultLowOe,
   output logic                          faultLineActive
);
   import mem_decode_pkg::*;

   accState_t state_q;
   accState_t state_d;
   logic [2:0] cnt_q;
   logic       onChipHit;
   logic       take;
   data_t      rspData_q;
   logic       rspOnChip_q;
   linkVec_t   rate_q;
   logic       tick_q [`LINK_COUNT];
   linkVec_t   rxToCore_q;
   linkVec_t   tx_q;
   logic       faultOe_q;
   logic       faultLine_q;

   dram_if #(.AW(AW)) dram ();

   dram_store #(.AW(AW)) uStore (
      .clock (clock),
      .bus   (dram)
   );

   // Address decode: only the first 4 Kbyte page of the signed map is on-chip
   assign onChipHit = (reqAddr[31:`ONCHIP_TAG_LSB] == `ONCHIP_TAG);
   assign onChipSel = reqValid && onChipHit;
   assign reqReady  = (state_q == ST_IDLE);
   assign take      = reqValid && reqReady;

   // External memory request issued in the cycle the access is taken
   assign dram.en    = take && !onChipHit;
   assign dram.we    = reqWrite;
   assign dram.addr  = reqAddr[AW+`WORD_LSB-1:`WORD_LSB];
   assign dram.wdata = reqWdata;
   assign dram.be    = reqBe;

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take) begin
               state_d = onChipHit ? ST_ACK : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cnt_q == 3'h1) begin
               state_d = ST_ACK;
            end
         end
         ST_ACK: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Wait counter stretches a DRAM access to the full memory cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_q <= 3'h0;
      end else if (take && !onChipHit) begin
         cnt_q <= 3'(`DRAM_CYCLES - 1);
      end else if (state_q == ST_WAIT) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end

   // Response data: DRAM read data on the last wait cycle, zero for on-chip
   always_ff @(posedge clock) begin
      if (srst) begin
         rspData_q   <= `RSP_DATA_RST;
         rspOnChip_q <= 1'b0;
      end else if (take && onChipHit) begin
         rspData_q   <= `RSP_DATA_RST;
         rspOnChip_q <= 1'b1;
      end else if (state_q == ST_WAIT && cnt_q == 3'h1) begin
         rspData_q   <= dram.rdata;
         rspOnChip_q <= 1'b0;
      end
   end

   assign rspValid  = (state_q == ST_ACK);
   assign rspData   = rspData_q;
   assign rspOnChip = rspOnChip_q;

   // Straps captured on every reset cycle and frozen once reset releases
   always_ff @(posedge clock) begin
      if (srst) begin
         rate_q <= {links123RateStrap, links123RateStrap, links123RateStrap, link0RateStrap};
      end
   end

   assign linkRateHigh = rate_q;

   // Per-link bit period timers: 4 cycles for 10 Mbit/s, 2 for 20 Mbit/s
   for (genvar g = 0; g < `LINK_COUNT; g++) begin : gLink
      logic [2:0] bitCnt_q;
      logic [2:0] period;

      assign period = rate_q[g] ? 3'(`LINK_FAST_CYCLES) : 3'(`LINK_SLOW_CYCLES);

      always_ff @(posedge clock) begin
         if (srst) begin
            bitCnt_q <= `BIT_CNT_RST;
            tick_q[g] <= 1'b0;
         end else begin
            tick_q[g] <= (bitCnt_q == period - 3'h1);
            bitCnt_q  <= (bitCnt_q == period - 3'h1) ? `BIT_CNT_RST : bitCnt_q + 3'h1;
         end
      end

      assign linkBitTick[g] = tick_q[g];
   end

   // Link pins: a floating input reads as idle low, which keeps the link quiet
   always_ff @(posedge clock) begin
      if (srst) begin
         rxToCore_q <= 4'h0;
         tx_q       <= 4'h0;
      end else begin
         rxToCore_q <= serialLinkRx & serialLinkRxConn;
         tx_q       <= coreLinkTx;
      end
   end

   assign linkRxToCore = rxToCore_q;
   assign serialLinkTx = tx_q;

   // Open-drain fault line: drive low on error, never drive high
   always_ff @(posedge clock) begin
      if (srst) begin
         faultOe_q   <= 1'b0;
         faultLine_q <= 1'b0;
      end else begin
         faultOe_q   <= coreError;
         faultLine_q <= !moduleFaultLowIn;
      end
   end

   assign moduleFaultLowOut = 1'b0;
   assign moduleFaultLowOe  = faultOe_q;
   assign faultLineActive   = faultLine_q;

   // Checks on decode, timing and pin behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   a_onchip_route: assert property (
      take && onChipHit |-> !dram.en ##1 (rspValid && rspOnChip))
      else $error("On-chip access reached external memory or was not answered");

   a_ext_route: assert property (
      take && !onChipHit |-> dram.en && dram.addr == reqAddr[AW+1:2])
      else $error("External access did not reach DRAM at its offset");

   a_addr_wrap: assert property (
      dram.en |-> dram.addr == reqAddr[AW+`WORD_LSB-1:`WORD_LSB] && !onChipHit)
      else $error("DRAM address depends on bits above the 4 Mbyte span");

   a_ext_base: assert property (
      take && reqAddr == `EXT_BASE |-> dram.en ##1 (state_q == ST_WAIT))
      else $error("First external address not sent to DRAM");

   a_dram_timing: assert property (
      take && !onChipHit |=> !rspValid [*6] ##1 (rspValid && !rspOnChip))
      else $error("DRAM access not answered after seven cycles");

   a_strap_group: assert property (
      $fell(srst) |-> linkRateHigh == {{3{$past(links123RateStrap)}}, $past(link0RateStrap)})
      else $error("Link rates do not follow their straps");

   a_fast_tick: assert property (
      linkBitTick[1] && linkRateHigh[1] |=> !linkBitTick[1] ##1 linkBitTick[1])
      else $error("Fast link bit period is not two cycles");

   a_slow_tick: assert property (
      linkBitTick[0] && !linkRateHigh[0] |=> !linkBitTick[0] [*3] ##1 linkBitTick[0])
      else $error("Slow link bit period is not four cycles");

   a_fault_pull: assert property (
      moduleFaultLowOe == $past(coreError) && moduleFaultLowOut == 1'b0)
      else $error("Fault line not pulled low one cycle after error");

   a_fault_sense: assert property (
      faultLineActive == !$past(moduleFaultLowIn))
      else $error("Low fault line not seen as active");

   a_rx_idle: assert property (
      (linkRxToCore & ~$past(serialLinkRxConn)) == 4'h0)
      else $error("Unconnected link input not held low");

   a_strap_hold: assert property (
      !$past(srst) |-> $stable(linkRateHigh))
      else $error("Link rate changed outside reset");

   a_sel_nodram: assert property (
      onChipSel |-> !dram.en)
      else $error("On-chip select raised together with a DRAM enable");

   a_ready_busy: assert property (
      take && !onChipHit |=> !reqReady [*7] ##1 reqReady)
      else $error("Port not held busy for the whole DRAM cycle");

   a_rsp_stand: assert property (
      $changed(rspData) |-> rspValid)
      else $error("Response data changed without an answer");

   a_tick_start: assert property (
      $fell(srst) |-> linkBitTick == 4'h0)
      else $error("Link bit tick present straight after reset");

   a_rx_pass: assert property (
      !$past(srst) |-> linkRxToCore == ($past(serialLinkRx) & $past(serialLinkRxConn)))
      else $error("Connected link input not passed to the core");

   a_fault_release: assert property (
      !coreError |=> !moduleFaultLowOe)
      else $error("Fault line still driven after the error cleared");

   // Busy-cycle counter: no access may hold the port beyond one memory cycle
   logic [3:0] busyCnt_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         busyCnt_q <= 4'h0;
      end else if (reqReady) begin
         busyCnt_q <= 4'h0;
      end else begin
         busyCnt_q <= busyCnt_q + 4'h1;
      end
   end

   a_busy_bound: assert property (
      busyCnt_q <= 4'(`DRAM_CYCLES))
      else $error("Access port busy longer than one memory cycle");

   c_dram_read: cover property (take && !onChipHit && !reqWrite ##7 rspValid);
   c_onchip: cover property (take && onChipHit ##1 rspValid);
   c_fast_link: cover property (linkRateHigh[0] && linkBitTick[0]);
   c_fault: cover property (moduleFaultLowOe && faultLineActive);
   c_dram_write: cover property (take && !onChipHit && reqWrite);

endmodule

// ---- tb/proc_model.sv ----
// Processor-side model issuing one memory access at a time
`timescale 1ns/1ps
module proc_model (
   input  wire logic             clock,
   output logic                  reqValid,
   output mem_decode_pkg::addr_t reqAddr,
   output logic                  reqWrite,
   output mem_decode_pkg::data_t reqWdata,
   output mem_decode_pkg::byteEn_t reqBe,
   input  wire logic             reqReady,
   input  wire logic             rspValid,
   input  mem_decode_pkg::data_t rspData,
   input  wire logic             rspOnChip
);
   import mem_decode_pkg::*;

   // Idle bus from time zero; request strobe is active high
   initial begin
      reqValid = 1'b0;
      reqAddr  = 32'h0000_0000;
      reqWrite = 1'b0;
      reqWdata = 32'h0000_0000;
      reqBe    = 4'h0;
   end

   // Hold the request until taken, then scramble released lines and count cycles to the answer
   task automatic access(input addr_t a, input logic w, input data_t d, input byteEn_t b,
                         output data_t q, output logic oc, output int lat);
      int n;
      n = 0;
      lat = -1;
      @(posedge clock);
      reqValid <= 1'b1;
      reqAddr  <= a;
      reqWrite <= w;
      reqWdata <= d;
      reqBe    <= b;
      do @(negedge clock); while (!reqReady);
      @(posedge clock);
      reqValid <= 1'b0;
      reqAddr  <= ~a;
      reqWdata <= ~d;
      reqBe    <= ~b;
      while (n < 50) begin
         @(negedge clock);
         n++;
         if (rspValid) begin
            lat = n;
            q = rspData;
            oc = rspOnChip;
            break;
         end
      end
   endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the memory decoder, link straps, link pins and fault line
`include "mem_decode_defs.svh"
`timescale 1ns/1ps
module testbench;
   import mem_decode_pkg::*;

   logic     clock = 1'b0;
   logic     srst = 1'b1;
   logic     reqValid, reqReady, reqWrite, onChipSel, rspValid, rspOnChip;
   addr_t    reqAddr;
   data_t    reqWdata, rspData, q;
   byteEn_t  reqBe;
   logic     link0RateStrap = 1'b0, links123RateStrap = 1'b0;
   linkVec_t linkRateHigh, linkBitTick, linkRxToCore, serialLinkTx;
   linkVec_t serialLinkRx = 4'h0, serialLinkRxConn = 4'h0, coreLinkTx = 4'h0;
   logic     coreError = 1'b0, otherFault = 1'b0;
   logic     moduleFaultLowIn, moduleFaultLowOut, moduleFaultLowOe, faultLineActive, oc;
   int       numErrors = 0, nChecks = 0, lat, p;

   // Shared fault line: pulled high unless some module drives it low
   assign moduleFaultLowIn = !((moduleFaultLowOe && !moduleFaultLowOut) || otherFault);

   // On-chip select as shown in the cycle each request is taken
   logic     selSeen;
   always @(negedge clock) begin
      if (reqValid && reqReady) begin
         selSeen <= onChipSel;
      end
   end

   initial forever #12.5 clock = ~clock;

   mem_decode_link_cfg #(.AW(8)) DUT (.clock(clock), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
      .reqAddr(reqAddr), .reqWrite(reqWrite), .reqWdata(reqWdata), .reqBe(reqBe), .onChipSel(onChipSel),
      .rspValid(rspValid), .rspData(rspData), .rspOnChip(rspOnChip), .link0RateStrap(link0RateStrap),
      .links123RateStrap(links123RateStrap), .linkRateHigh(linkRateHigh), .linkBitTick(linkBitTick),
      .serialLinkRx(serialLinkRx), .serialLinkRxConn(serialLinkRxConn), .linkRxToCore(linkRxToCore),
      .coreLinkTx(coreLinkTx), .serialLinkTx(serialLinkTx), .coreError(coreError),
      .moduleFaultLowIn(moduleFaultLowIn), .moduleFaultLowOut(moduleFaultLowOut),
      .moduleFaultLowOe(moduleFaultLowOe), .faultLineActive(faultLineActive));

   proc_model PM (.clock(clock), .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite),
      .reqWdata(reqWdata), .reqBe(reqBe), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .rspOnChip(rspOnChip));

   task automatic chk(input logic ok, input string msg);
      nChecks++;
      if (ok !== 1'b1) begin
         numErrors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Reset for 12 cycles with the given strap levels
   task automatic do_reset(input logic s0, input logic s1);
      @(posedge clock);
      srst <= 1'b1;
      link0RateStrap <= s0;
      links123RateStrap <= s1;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
   endtask

   // Spacing in cycles between two ticks of one link
   task automatic period(input int i, output int n);
      n = 0;
      repeat (20) begin
         @(negedge clock);
         if (linkBitTick[i] === 1'b1) break;
      end
      repeat (20) begin
         @(negedge clock);
         n++;
         if (linkBitTick[i] === 1'b1) break;
      end
   endtask

   task automatic t_memory;
      PM.access(32'h8000_1000, 1'b1, 32'h1234_5678, 4'hf, q, oc, lat);
      chk(lat == `DRAM_CYCLES && oc === 1'b0 && selSeen === 1'b0, "first external word");
      PM.access(32'h8000_0000, 1'b1, 32'hffff_ffff, 4'hf, q, oc, lat);
      chk(lat == 1 && oc === 1'b1 && selSeen === 1'b1, "on-chip write answer");
      PM.access(32'h8000_0ffc, 1'b0, 32'h0, 4'hf, q, oc, lat);
      chk(lat == 1 && oc === 1'b1 && selSeen === 1'b1, "top on-chip word");
      PM.access(32'h8000_1000, 1'b0, 32'h0, 4'hf, q, oc, lat);
      chk(q === 32'h1234_5678 && lat == `DRAM_CYCLES, "external read back");
      PM.access(32'h8000_1400, 1'b0, 32'h0, 4'hf, q, oc, lat);
      chk(q === 32'h1234_5678, "alias one span up");
      PM.access(32'h0000_1000, 1'b0, 32'h0, 4'hf, q, oc, lat);
      chk(q === 32'h1234_5678 && oc === 1'b0 && selSeen === 1'b0, "alias in positive space");
      PM.access(32'h8000_1004, 1'b1, 32'haabb_ccdd, 4'hf, q, oc, lat);
      PM.access(32'h8000_1004, 1'b1, 32'h1122_3344, 4'h1, q, oc, lat);
      PM.access(32'h8000_1004, 1'b0, 32'h0, 4'hf, q, oc, lat);
      chk(q === 32'haabb_cc44, "byte enable merge");
      $display("t_memory done");
   endtask

   task automatic t_straps;
      do_reset(1'b0, 1'b1);
      @(negedge clock);
      chk(linkRateHigh === 4'b1110, "straps low/high");
      period(0, p);
      chk(p == `LINK_SLOW_CYCLES, "link0 slow period");
      period(2, p);
      chk(p == `LINK_FAST_CYCLES, "link2 fast period");
      @(posedge clock);
      link0RateStrap <= 1'b1;
      links123RateStrap <= 1'b0;
      repeat (4) @(negedge clock);
      chk(linkRateHigh === 4'b1110, "strap change outside reset");
      do_reset(1'b1, 1'b0);
      @(negedge clock);
      chk(linkRateHigh === 4'b0001, "straps high/low");
      period(0, p);
      chk(p == `LINK_FAST_CYCLES, "link0 fast period");
      period(3, p);
      chk(p == `LINK_SLOW_CYCLES, "link3 slow period");
      $display("t_straps done");
   endtask

   task automatic t_links;
      @(posedge clock);
      serialLinkRx <= 4'hf;
      serialLinkRxConn <= 4'h0;
      coreLinkTx <= 4'h5;
      repeat (2) @(negedge clock);
      chk(linkRxToCore === 4'h0 && serialLinkTx === 4'h5, "open inputs idle low");
      @(posedge clock);
      serialLinkRx <= 4'ha;
      serialLinkRxConn <= 4'hf;
      coreLinkTx <= 4'ha;
      repeat (2) @(negedge clock);
      chk(linkRxToCore === 4'ha && serialLinkTx === 4'ha, "connected links pass");
      $display("t_links done");
   endtask

   task automatic t_fault;
      @(posedge clock);
      coreError <= 1'b1;
      repeat (2) @(negedge clock);
      chk(moduleFaultLowOe === 1'b1 && moduleFaultLowOut === 1'b0, "fault drives low");
      @(negedge clock);
      chk(faultLineActive === 1'b1, "own fault seen on line");
      @(posedge clock);
      coreError <= 1'b0;
      repeat (3) @(negedge clock);
      chk(moduleFaultLowOe === 1'b0 && faultLineActive === 1'b0, "line released");
      @(posedge clock);
      otherFault <= 1'b1;
      repeat (2) @(negedge clock);
      chk(faultLineActive === 1'b1 && moduleFaultLowOe === 1'b0, "other module fault");
      @(posedge clock);
      otherFault <= 1'b0;
      $display("t_fault done");
   endtask

   initial begin
      do_reset(1'b1, 1'b1);
      t_memory();
      t_straps();
      t_links();
      t_fault();
      close_out();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge clock);
      numErrors++;
      $display("MISMATCH %0t watchdog expired", $time);
      close_out();
   end
endmodule
